/* include/qpc_params.svh */
// Purpose: Register offsets, field positions and reset values of the quad prescaler counter.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Included by the package and by the counter core.
`ifndef QPC_PARAMS_SVH
`define QPC_PARAMS_SVH

// ==========================================================================
// Register byte offsets
`define QPC_OFS_STATUS 8'h00
`define QPC_OFS_DATA 8'h04
`define QPC_OFS_CONTROL 8'h08
`define QPC_OFS_IRQ_MASK 8'h0C
`define QPC_OFS_GENERIC 8'h10
`define QPC_OFS_ADDRESS 8'h14
`define QPC_OFS_CFG0 8'h20
`define QPC_OFS_CFG_STEP 8'h04
`define QPC_ADDR_W 8

// ==========================================================================
// Status register fields
`define QPC_ST_SEL_LO 0
`define QPC_ST_CLR_EN 2
`define QPC_ST_ICF 3
`define QPC_ST_OVF_LO 4

// ==========================================================================
// Control and configuration fields
`define QPC_CTL_DISABLE 0
`define QPC_CTL_FORCE 1
`define QPC_CFG_IRQ_EN 8
`define QPC_CFG_RST_OVF 9

// ==========================================================================
// Reset values
`define QPC_RST_COUNT 8'h00
`define QPC_RST_CFG 10'h080
`define QPC_RST_MASK 4'hF
`define QPC_NUM_CNT 4

`endif

/* include/qpc_pkg.sv */
// Purpose: Types shared by the quad prescaler counter.
// Assumes: Constants come from qpc_params.svh.
// Notes: Holds types only.
`include "qpc_params.svh"

package qpc_pkg;
   // ==========================================================================
   // Types
   typedef logic [7:0] count_type;
   typedef logic [9:0] cfg_type;
   typedef logic [3:0] lane_type;
   typedef logic [`QPC_ADDR_W-1:0] addr_type;
   typedef logic [31:0] word_type;
   typedef enum logic [1:0] {
      SEL_CNT0 = 2'b00,
      SEL_CNT1 = 2'b01,
      SEL_CNT2 = 2'b10,
      SEL_CNT3 = 2'b11
   } counter_sel_type;
endpackage

/* core/quad_prescaler_counter.sv */
// Purpose: Four 8-bit event counters with overflow detection, test gating and an APB register port.
// Assumes: 125 MHz CLK, APB master keeping the usual setup and access phases.
// Notes: Field inputs are asynchronous and pass a three-stage synchroniser.
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "qpc_params.svh"

module quad_prescaler_counter #(
   parameter logic [7:0] GENERIC_CODE = 8'h5A, // Arbitrary value.
   parameter logic [7:0] MODULE_ADDR = 8'h21
) (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire qpc_pkg::addr_type PADDR,
   input wire qpc_pkg::word_type PWDATA,
   output qpc_pkg::word_type PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire qpc_pkg::lane_type FIELD_IN,
   output logic IRQ
);
   import qpc_pkg::*;

   // ==========================================================================
   // Reset release
   logic rst_meta_reg;
   logic rst_n;

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // ==========================================================================
   // Helpers
   function automatic logic level_bit(input cfg_type cfg, input count_type value);
      level_bit = |(cfg[7:0] & value);
   endfunction

   // ==========================================================================
   // Bus decode
   logic [1:0] sel_reg;
   logic clr_en_reg;
   logic icf_reg;
   logic in_disable_reg;
   logic force_reg;
   lane_type mask_reg;
   lane_type ovf_reg;
   cfg_type cfg_reg [`QPC_NUM_CNT];
   count_type cnt_reg [`QPC_NUM_CNT];
   word_type prdata_reg;
   word_type rd_value;

   wire setup_rd = PSEL & ~PENABLE & ~PWRITE;
   wire acc_done = PSEL & PENABLE;
   wire wr_done = acc_done & PWRITE;
   wire rd_done = acc_done & ~PWRITE;
   wire hit_status = PADDR == `QPC_OFS_STATUS;
   wire hit_data = PADDR == `QPC_OFS_DATA;
   wire hit_control = PADDR == `QPC_OFS_CONTROL;
   wire hit_mask = PADDR == `QPC_OFS_IRQ_MASK;
   wire hit_generic = PADDR == `QPC_OFS_GENERIC;
   wire hit_address = PADDR == `QPC_OFS_ADDRESS;
   wire cfg_window = (PADDR >= `QPC_OFS_CFG0) && (PADDR[1:0] == 2'b00)
      && (PADDR < `QPC_OFS_CFG0 + `QPC_NUM_CNT * `QPC_OFS_CFG_STEP);
   wire [1:0] cfg_idx = PADDR[3:2];
   wire hit_any = hit_status | hit_data | hit_control | hit_mask | hit_generic | hit_address | cfg_window;
   wire hold = PSEL & ~PWRITE & hit_data;
   wire status_rd_done = rd_done & hit_status;
   wire data_rd_done = rd_done & hit_data;
   wire [7:0] status_value = {ovf_reg, icf_reg, clr_en_reg, sel_reg};

   assign PREADY = 1'b1;
   assign PSLVERR = acc_done & ~hit_any;
   assign PRDATA = prdata_reg;

   // Read multiplexer is sampled in the setup phase; the hold keeps the count frozen until the access ends.
   assign rd_value = hit_status ? {24'h00_0000, status_value} :
      hit_data ? {24'h00_0000, cnt_reg[sel_reg]} :
      hit_control ? {30'h0000_0000, force_reg, in_disable_reg} :
      hit_mask ? {28'h000_0000, mask_reg} :
      hit_generic ? {24'h00_0000, GENERIC_CODE} :
      hit_address ? {24'h00_0000, MODULE_ADDR} :
      cfg_window ? {22'h00_0000, cfg_reg[cfg_idx]} : 32'h0000_0000;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         prdata_reg <= 32'h0000_0000;
      end else begin
         prdata_reg <= setup_rd ? rd_value : 32'h0000_0000;
      end
   end

   // ==========================================================================
   // Software registers
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         sel_reg <= 2'b00;
         clr_en_reg <= 1'b0;
         icf_reg <= 1'b0;
         in_disable_reg <= 1'b0;
         force_reg <= 1'b0;
         mask_reg <= `QPC_RST_MASK;
      end else begin
         if (wr_done && hit_status) begin
            sel_reg <= PWDATA[`QPC_ST_SEL_LO +: 2];
            clr_en_reg <= PWDATA[`QPC_ST_CLR_EN];
            icf_reg <= PWDATA[`QPC_ST_ICF];
         end else if (data_rd_done) begin
            clr_en_reg <= 1'b0;
         end
         if (wr_done && hit_control) begin
            in_disable_reg <= PWDATA[`QPC_CTL_DISABLE];
            force_reg <= PWDATA[`QPC_CTL_FORCE];
         end
         if (wr_done && hit_mask) begin
            mask_reg <= PWDATA[3:0];
         end
      end
   end

   // ==========================================================================
   // Field input synchroniser and gating
   lane_type sync1_reg;
   lane_type sync2_reg;
   lane_type sync3_reg;
   lane_type field_reg;
   lane_type gated_prev_reg;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= 4'h0;
         sync2_reg <= 4'h0;
         sync3_reg <= 4'h0;
         field_reg <= 4'h0;
      end else begin
         sync1_reg <= FIELD_IN;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         field_reg <= (sync2_reg & sync3_reg) | (field_reg & (sync2_reg | sync3_reg));
      end
   end

   wire [3:0] gated = (field_reg & {4{~in_disable_reg}}) | {4{force_reg}};
   wire [3:0] evt = gated & ~gated_prev_reg;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         gated_prev_reg <= 4'h0;
      end else begin
         gated_prev_reg <= gated;
      end
   end

   // ==========================================================================
   // Counters
   lane_type pend_reg;
   lane_type apply;
   lane_type ovf_hit;
   lane_type cfg_wr;

   for (genvar i = 0; i < `QPC_NUM_CNT; i++) begin : g_cnt
      count_type nxt;
      count_type cnt_next;
      wire clr = data_rd_done & clr_en_reg & (sel_reg == 2'(i));
      assign apply[i] = ~hold & (evt[i] | pend_reg[i]);
      assign nxt = cnt_reg[i] + 8'h01;
      assign ovf_hit[i] = apply[i] & level_bit(cfg_reg[i], cnt_reg[i]) & ~level_bit(cfg_reg[i], nxt);
      assign cfg_wr[i] = wr_done & cfg_window & (cfg_idx == 2'(i));
      assign cnt_next = clr ? `QPC_RST_COUNT :
         (ovf_hit[i] && cfg_reg[i][`QPC_CFG_RST_OVF]) ? `QPC_RST_COUNT :
         apply[i] ? nxt : cnt_reg[i];

      always_ff @(posedge CLK or negedge rst_n) begin
         if (!rst_n) begin
            cnt_reg[i] <= `QPC_RST_COUNT;
            cfg_reg[i] <= `QPC_RST_CFG;
            pend_reg[i] <= 1'b0;
         end else begin
            cnt_reg[i] <= cnt_next;
            pend_reg[i] <= hold ? (pend_reg[i] | evt[i]) : (pend_reg[i] & evt[i]);
            if (cfg_wr[i]) begin
               cfg_reg[i] <= PWDATA[9:0];
            end
         end
      end
   end

   // ==========================================================================
   // Overflow flags and interrupt
   wire [3:0] irq_en = {cfg_reg[3][`QPC_CFG_IRQ_EN], cfg_reg[2][`QPC_CFG_IRQ_EN],
      cfg_reg[1][`QPC_CFG_IRQ_EN], cfg_reg[0][`QPC_CFG_IRQ_EN]};
   wire ovf_clear = status_rd_done & icf_reg;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         ovf_reg <= 4'h0;
      end else begin
         ovf_reg <= (ovf_clear ? 4'h0 : ovf_reg) | ovf_hit;
      end
   end

   assign IRQ = |(ovf_reg & irq_en & mask_reg);

   // ==========================================================================
   // Checks
   sequence s_held_event;
      hold && evt[0] && !pend_reg[0];
   endsequence

   sequence s_release;
      pend_reg[0] && !hold && !evt[0];
   endsequence

   AST_HOLD_FREEZE: assert property (@(posedge CLK) disable iff (!rst_n)
      hold && !data_rd_done |=> cnt_reg[0] == $past(cnt_reg[0]) && cnt_reg[3] == $past(cnt_reg[3]))
      else $error("Counter moved during a data read.");
   AST_STATUS_NO_HOLD: assert property (@(posedge CLK) disable iff (!rst_n)
      PSEL && hit_status && evt[1] |-> apply[1])
      else $error("Status access held a counter.");
   AST_DISABLE: assert property (@(posedge CLK) disable iff (!rst_n)
      in_disable_reg && $past(in_disable_reg) && !force_reg && !$past(force_reg) |-> evt == 4'h0)
      else $error("Field event passed while inputs disabled.");
   AST_FORCE: assert property (@(posedge CLK) disable iff (!rst_n)
      $rose(force_reg) && $past(in_disable_reg) && in_disable_reg && $past(gated) == 4'h0 |-> evt == 4'hF)
      else $error("Force did not step all counters.");
   AST_PASS: assert property (@(posedge CLK) disable iff (!rst_n)
      !in_disable_reg && !force_reg |-> gated == field_reg)
      else $error("Gating altered a field input.");
   AST_HELD_EVENT: assert property (@(posedge CLK) disable iff (!rst_n)
      s_held_event |=> pend_reg[0])
      else $error("Event lost during hold.");
   AST_RELEASE: assert property (@(posedge CLK) disable iff (!rst_n)
      s_release ##0 !data_rd_done |=> !pend_reg[0] && cnt_reg[0] != $past(cnt_reg[0]))
      else $error("Pending event not applied after hold.");
   AST_STEP: assert property (@(posedge CLK) disable iff (!rst_n)
      apply[0] && !ovf_hit[0] |=> cnt_reg[0] == 8'($past(cnt_reg[0]) + 8'h01))
      else $error("Counter did not step by one.");
   AST_RST_OVF: assert property (@(posedge CLK) disable iff (!rst_n)
      ovf_hit[0] && cfg_reg[0][`QPC_CFG_RST_OVF] |=> cnt_reg[0] == 8'h00)
      else $error("Counter not cleared at overflow.");
   AST_OVF_SET: assert property (@(posedge CLK) disable iff (!rst_n)
      ovf_hit[2] |=> ovf_reg[2] ##1 ovf_reg[2] || $past(ovf_clear))
      else $error("Overflow flag not set.");
   AST_OVF_CLEAR: assert property (@(posedge CLK) disable iff (!rst_n)
      ovf_clear && ovf_hit == 4'h0 |=> ovf_reg == 4'h0 && !IRQ)
      else $error("Status read did not clear overflow flags.");
   AST_IRQ: assert property (@(posedge CLK) disable iff (!rst_n)
      $rose(ovf_reg[1]) && irq_en[1] && mask_reg[1] |-> IRQ)
      else $error("Enabled overflow raised no interrupt.");
   AST_DATA_CLEAR: assert property (@(posedge CLK) disable iff (!rst_n)
      data_rd_done && clr_en_reg |=> !clr_en_reg && cnt_reg[$past(sel_reg)] == 8'h00)
      else $error("Data read did not clear counter.");
   AST_STROBE: assert property (@(posedge CLK) disable iff (!rst_n)
      !(PSEL && PENABLE && !PWRITE) |-> PRDATA == 32'h0000_0000)
      else $error("Read data driven outside a read strobe.");

   // ==========================================================================
   // Read path, configuration and counter checks
   sequence s_setup_data;
      setup_rd && hit_data;
   endsequence

   sequence s_force_rise;
      $rose(force_reg) && in_disable_reg && $past(gated) == 4'h0 && !hold;
   endsequence

   AST_DATA_RD: assert property (@(posedge CLK) disable iff (!rst_n)
      s_setup_data |=> PRDATA == {24'h00_0000, cnt_reg[sel_reg]})
      else $error("Data read returned a count other than the selected counter.");
   AST_STATUS_RD: assert property (@(posedge CLK) disable iff (!rst_n)
      setup_rd && hit_status |=> PRDATA[7:4] == $past(ovf_reg) && PRDATA[31:8] == 24'h00_0000)
      else $error("Status read did not show the overflow flags.");
   AST_GENERIC_RD: assert property (@(posedge CLK) disable iff (!rst_n)
      setup_rd && hit_generic |=> PRDATA == {24'h00_0000, GENERIC_CODE})
      else $error("Generic code read returned a wrong word.");
   AST_ADDRESS_RD: assert property (@(posedge CLK) disable iff (!rst_n)
      setup_rd && hit_address |=> PRDATA == {24'h00_0000, MODULE_ADDR})
      else $error("Module address read returned a wrong word.");
   AST_HOLD_ALL: assert property (@(posedge CLK) disable iff (!rst_n)
      hold && !data_rd_done |=> cnt_reg[1] == $past(cnt_reg[1]) && cnt_reg[2] == $past(cnt_reg[2]))
      else $error("A counter moved during a data read.");
   AST_WRITE_NO_HOLD: assert property (@(posedge CLK) disable iff (!rst_n)
      PSEL && PWRITE && evt[1] |-> apply[1])
      else $error("A write held a counter.");
   AST_CFG_WR: assert property (@(posedge CLK) disable iff (!rst_n)
      wr_done && cfg_window && cfg_idx == 2'h2 |=> cfg_reg[2] == $past(PWDATA[9:0]) && cfg_reg[1] == $past(cfg_reg[1]))
      else $error("Configuration write did not land on its own counter only.");
   AST_CTRL_WR: assert property (@(posedge CLK) disable iff (!rst_n)
      wr_done && hit_control |=> in_disable_reg == $past(PWDATA[`QPC_CTL_DISABLE]) && force_reg == $past(PWDATA[`QPC_CTL_FORCE]))
      else $error("Control write did not set disable and force.");
   AST_FORCE_STEP: assert property (@(posedge CLK) disable iff (!rst_n)
      s_force_rise |=> cnt_reg[3] != $past(cnt_reg[3]) && cnt_reg[1] != $past(cnt_reg[1]))
      else $error("Force pulse did not step the counters.");
   AST_SYNC_AGREE: assert property (@(posedge CLK) disable iff (!rst_n)
      $changed(field_reg[0]) |-> $past(sync2_reg[0]) == $past(sync3_reg[0]))
      else $error("Field input changed before two stages agreed.");
   AST_OVF_STICKY: assert property (@(posedge CLK) disable iff (!rst_n)
      ovf_reg[0] && !ovf_clear |=> ovf_reg[0])
      else $error("Overflow flag dropped without a clearing read.");
   AST_OVF_CAUSE: assert property (@(posedge CLK) disable iff (!rst_n)
      !ovf_reg[3] && !ovf_hit[3] |=> !ovf_reg[3])
      else $error("Overflow flag set without an overflow.");
   AST_WRAP_NO_RST: assert property (@(posedge CLK) disable iff (!rst_n)
      ovf_hit[2] && !cfg_reg[2][`QPC_CFG_RST_OVF] |=> cnt_reg[2] == 8'($past(cnt_reg[2]) + 8'h01))
      else $error("Counter without reset on overflow did not keep counting.");
   AST_STATUS_KEEP: assert property (@(posedge CLK) disable iff (!rst_n)
      status_rd_done && !icf_reg && ovf_reg[1] |=> ovf_reg[1])
      else $error("Status read without clear flag cleared an overflow.");
   AST_CLR_EN_KEEP: assert property (@(posedge CLK) disable iff (!rst_n)
      clr_en_reg && !data_rd_done && !(wr_done && hit_status) |=> clr_en_reg)
      else $error("Clear enable dropped without a data read.");
   AST_DATA_KEEP: assert property (@(posedge CLK) disable iff (!rst_n)
      data_rd_done && !clr_en_reg |=> cnt_reg[$past(sel_reg)] == $past(cnt_reg[sel_reg]))
      else $error("Data read without clear enable altered the counter.");
   AST_PEND_KEEP: assert property (@(posedge CLK) disable iff (!rst_n)
      pend_reg[1] && hold |=> pend_reg[1])
      else $error("Pending event dropped during a hold.");
endmodule // quad_prescaler_counter
`default_nettype wire

/* test/apb_master.sv */
// Purpose: APB master standing in for the module bus controller.
// Assumes: The slave may insert any number of wait states.
// Notes: Requests change only just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module apb_master (
   input wire logic clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output qpc_pkg::addr_type paddr,
   output qpc_pkg::word_type pwdata,
   input wire logic pready
);
   import qpc_pkg::*;
   // ==========================================================================
   // Bus cycle
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
   end
   // The request is held until pready is seen high at a rising edge.
   task automatic xfer(input logic wr, input addr_type a, input word_type d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule // apb_master
`default_nettype wire

/* test/quad_prescaler_counter_test.sv */
// Purpose: Self-checking bench for the quad prescaler counter.
// Assumes: Zero wait state slave; field events counted a few cycles after a rise.
// Notes: Reads queue their expected word; a monitor compares at the access edge.
`timescale 1ns/1ns
`default_nettype none
`include "qpc_params.svh"
module quad_prescaler_counter_test;
   import qpc_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, irq;
   addr_type paddr;
   word_type pwdata, prdata;
   lane_type field_in = '0;
   lane_type ovf = '0;
   lane_type mask = 4'hF;
   logic [3:0] stw = '0;
   logic [32:0] exp_q[$];
   count_type cnt[4] = '{default: 8'h00};
   cfg_type cfgm[4] = '{default: 10'h080};
   int fail_count = 0;
   int num_checks = 0;
   int seed = 59965;
   always #4 clk = ~clk;
   quad_prescaler_counter u_quad_prescaler_counter (.CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .FIELD_IN(field_in), .IRQ(irq));
   apb_master u_apb_master (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready));
   // ==========================================================================
   // Checking
   task automatic check_rd(input logic [32:0] got, input logic [32:0] want);
      num_checks++;
      if (got !== want) begin
         fail_count++;
         $display("BAD %0t got %h want %h", $time, got, want);
      end
   endtask
   task automatic check_irq(input logic want);
      num_checks++;
      if (irq !== want) begin
         fail_count++;
         $display("BAD %0t got %h want %h", $time, irq, want);
      end
   endtask
   always @(posedge clk) begin
      if (psel && penable && pready && !pwrite) check_rd({pslverr, prdata}, exp_q.pop_front());
   end
   task automatic results();
      if (exp_q.size() != 0) fail_count++;
      if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      results();
   end
   // ==========================================================================
   // Model and bus helpers
   function automatic void step(input int i);
      count_type nw;
      nw = cnt[i] + 8'h01;
      if ((cnt[i] & ~nw & cfgm[i][7:0]) != 8'h00) begin
         ovf[i] = 1'b1;
         if (cfgm[i][`QPC_CFG_RST_OVF]) nw = 8'h00;
      end
      cnt[i] = nw;
   endfunction
   function automatic logic irq_exp();
      return |(ovf & mask & {cfgm[3][8], cfgm[2][8], cfgm[1][8], cfgm[0][8]});
   endfunction
   function automatic logic [32:0] st();
      return {25'h000_0000, ovf, stw};
   endfunction
   task automatic wr(input addr_type a, input word_type d);
      u_apb_master.xfer(1'b1, a, d);
   endtask
   task automatic rd(input addr_type a, input logic [32:0] want);
      exp_q.push_back(want);
      u_apb_master.xfer(1'b0, a, 32'h0000_0000);
   endtask
   task automatic field(input lane_type m, input logic counts);
      @(posedge clk);
      field_in <= m;
      repeat (8) @(posedge clk);
      field_in <= '0;
      repeat (10) @(posedge clk);
      if (counts) for (int i = 0; i < 4; i++) if (m[i]) step(i);
   endtask
   task automatic frc();
      wr(`QPC_OFS_CONTROL, 32'h0000_0003);
      wr(`QPC_OFS_CONTROL, 32'h0000_0001);
      for (int i = 0; i < 4; i++) step(i);
      @(posedge clk);
   endtask
   // ==========================================================================
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rd(`QPC_OFS_STATUS, 33'h0_0000_0000);
      rd(`QPC_OFS_CONTROL, 33'h0_0000_0000);
      rd(`QPC_OFS_IRQ_MASK, 33'h0_0000_000F);
      rd(`QPC_OFS_GENERIC, 33'h0_0000_005A);
      rd(`QPC_OFS_ADDRESS, 33'h0_0000_0021);
      for (int i = 0; i < 4; i++) rd(addr_type'(`QPC_OFS_CFG0 + 4 * i), 33'h0_0000_0080);
      rd(8'h18, 33'h1_0000_0000);
      wr(`QPC_OFS_GENERIC, 32'h0000_0000);
      rd(`QPC_OFS_GENERIC, 33'h0_0000_005A);
      repeat (6) field(lane_type'($random(seed)), 1'b1);
      wr(`QPC_OFS_CONTROL, 32'h0000_0001);
      repeat (2) field(4'hF, 1'b0);
      cfgm[1] = 10'h304;
      cfgm[2] = 10'h104;
      cfgm[3] = 10'h001;
      for (int i = 0; i < 4; i++) wr(addr_type'(`QPC_OFS_CFG0 + 4 * i), 32'(cfgm[i]));
      // Force pulses with the field inputs blocked walk the radix of counters 1 to 3.
      repeat (12) begin
         frc();
         check_irq(irq_exp());
      end
      for (int i = 0; i < 4; i++) begin
         stw = 4'(i);
         wr(`QPC_OFS_STATUS, 32'(stw));
         rd(`QPC_OFS_DATA, {25'h000_0000, cnt[i]});
      end
      rd(`QPC_OFS_STATUS, st());
      rd(`QPC_OFS_STATUS, st());
      mask = 4'h0;
      wr(`QPC_OFS_IRQ_MASK, 32'h0000_0000);
      @(posedge clk);
      check_irq(1'b0);
      mask = 4'hF;
      wr(`QPC_OFS_IRQ_MASK, 32'h0000_000F);
      @(posedge clk);
      check_irq(irq_exp());
      stw = 4'h8;
      wr(`QPC_OFS_STATUS, 32'(stw));
      rd(`QPC_OFS_STATUS, st());
      ovf = '0;
      @(posedge clk);
      check_irq(1'b0);
      rd(`QPC_OFS_STATUS, st());
      stw = 4'h5;
      wr(`QPC_OFS_STATUS, 32'(stw));
      rd(`QPC_OFS_DATA, {25'h000_0000, cnt[1]});
      cnt[1] = 8'h00;
      stw = 4'h1;
      rd(`QPC_OFS_STATUS, st());
      rd(`QPC_OFS_DATA, 33'h0_0000_0000);
      wr(`QPC_OFS_CONTROL, 32'h0000_0000);
      // Status writes never delay a field event; a data read delays one without losing it.
      fork
         field(4'h2, 1'b1);
         repeat (6) u_apb_master.xfer(1'b1, `QPC_OFS_STATUS, 32'(stw));
      join
      fork
         field(4'h3, 1'b1);
         begin
            repeat (3) @(posedge clk);
            rd(`QPC_OFS_DATA, {25'h000_0000, cnt[1]});
         end
      join
      rd(`QPC_OFS_DATA, {25'h000_0000, cnt[1]});
      repeat (2) @(posedge clk);
      results();
   end
endmodule // quad_prescaler_counter_test
`default_nettype wire
